// [hdl/sai_pkg.sv]
// Constants and types of the sync activity and interface select block
package sai_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_MHZ = 10;
   // Activity window, microseconds
   localparam int unsigned ACT_TMO_US = 50000;
   localparam int unsigned TMO_W = 20;
   localparam logic [TMO_W-1:0] ACT_TMO_CYC =
      TMO_W'(ACT_TMO_US * CLK_MHZ);

   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_OUT_MODE = 8'h10;
   localparam logic [7:0] IDX_DET_STAT = 8'h11;
   localparam logic [7:0] IDX_SRC_OVR = 8'h12;
   localparam logic [7:0] IDX_IRQ_ST = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int unsigned OM_TRISTATE = 3;
   localparam int unsigned OM_DET_POL = 2;
   localparam int unsigned ST_HS = 7;
   localparam int unsigned ST_SOG = 6;
   localparam int unsigned ST_VS = 5;
   localparam int unsigned ST_DCLK = 4;
   localparam int unsigned ST_SEL_IF = 3;
   localparam int unsigned ST_SEL_HS = 2;
   localparam int unsigned ST_SEL_VS = 1;
   localparam int unsigned OV_IF = 7;
   localparam int unsigned OV_IF_PREF = 6;
   localparam int unsigned OV_HS = 5;
   localparam int unsigned OV_HS_PREF = 4;
   localparam int unsigned OV_VS = 3;
   localparam int unsigned OV_VS_PREF = 2;

   // ************************************************************
   // Reset values and implemented bits
   // ************************************************************
   localparam logic [7:0] OUT_MODE_RST = 8'h00;
   localparam logic [7:0] SRC_OVR_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;
   localparam logic [7:0] OUT_MODE_BITS = 8'h0C;
   localparam logic [7:0] SRC_OVR_BITS = 8'hFC;
   localparam logic [7:0] IRQ_BITS = 8'hF8;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic hs;
      logic green_embedded_sync;
      logic vs;
      logic dclk;
   } sai_det_t;

endpackage : sai_pkg

// [hdl/sai_ctrl.sv]
// Sync activity detection and interface selection with AHB-Lite registers
// What this block does
// - Tristate bit floats data outputs, default zero
// - Polarity bit sets sync detect output level
// - Hsync detect set only while input toggles
// - Green sync detect set on green activity
// - Vsync detect set only while input toggles
// - Link clock detect set on clock activity
// - Analog detected is OR of three detects
// - Auto interface select; neither detected means seek
// - Interface override forces preference bit value
// - Interface preference: zero analog, one digital
// - Auto hsync select; both or neither use preference
// - Hsync override forces hsync preference value
// - Hsync source zero input, one green
// - Auto vsync select follows vsync detect
// - Vsync override forces vsync preference value
// - Interface override zero auto, resets zero
// - Hsync override and preference reset zero
// - Vsync source zero input, one separator
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps

// ************************************************************
// Activity detector
// ************************************************************
module sai_act_det #(
   parameter logic [sai_pkg::TMO_W-1:0] TMO = sai_pkg::ACT_TMO_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Monitored pin
   input wire logic pin_i,
   // Activity flag
   output logic active_o
);

   logic sync1;
   logic sync2;
   logic last;
   logic [sai_pkg::TMO_W-1:0] cnt;
   logic [sai_pkg::TMO_W-1:0] next_cnt;
   logic next_active;

   always_comb
   begin
      if (sync2 != last)
      begin
         next_cnt = TMO;
      end
      else if (cnt != '0)
      begin
         next_cnt = cnt - 1'b1;
      end
      else
      begin
         next_cnt = '0;
      end
      next_active = (next_cnt != '0);
   end

   always_ff @(posedge mclk_i)
   begin
      // Chain follows the pin in reset too, so no false edge after it
      sync1 <= pin_i;
      sync2 <= sync1;
      last <= sync2;
      if (sys_rst_i)
      begin
         cnt <= '0;
         active_o <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         active_o <= next_active;
      end
   end

endmodule : sai_act_det

// ************************************************************
// Top level
// ************************************************************
module sai_ctrl #(
   parameter logic [sai_pkg::TMO_W-1:0] ACT_TMO_CYC =
      sai_pkg::ACT_TMO_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Video sync pins
   input wire logic hsync_i,
   input wire logic green_sync_i,
   input wire logic vsync_i,
   input wire logic link_clk_i,
   // Status and control outputs
   output logic sync_detect_o,
   output logic out_oe_n_o,
   output logic selected_interface_o,
   output logic selected_hsync_source_o,
   output logic selected_vsync_source_o,
   output logic seek_mode_o,
   output logic irq_o
);

   sai_pkg::sai_det_t det;
   sai_pkg::sai_det_t det_q;

   logic [7:0] out_mode;
   logic [7:0] src_ovr;
   logic [7:0] irq_st;
   logic [7:0] irq_mask;
   logic [7:0] next_out_mode;
   logic [7:0] next_src_ovr;
   logic [7:0] next_irq_st;
   logic [7:0] next_irq_mask;
   logic [7:0] irq_set;
   logic [7:0] irq_clr;

   logic wr_pend;
   logic [7:0] wr_idx;
   logic next_wr_pend;
   logic [7:0] next_wr_idx;
   logic [31:0] next_rdata;
   logic addr_ok;
   logic ap_valid;
   logic [7:0] ap_idx;
   logic [7:0] rd_val;

   logic analog_det;
   logic any_det;
   logic next_sel_if;
   logic next_sel_hs;
   logic next_sel_vs;
   logic next_seek;

   // ************************************************************
   // Detectors
   // ************************************************************
   sai_act_det #(.TMO(ACT_TMO_CYC)) u_det_hs (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(hsync_i),
      .active_o(det.hs)
   );

   sai_act_det #(.TMO(ACT_TMO_CYC)) u_det_sog (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(green_sync_i),
      .active_o(det.green_embedded_sync)
   );

   sai_act_det #(.TMO(ACT_TMO_CYC)) u_det_vs (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(vsync_i),
      .active_o(det.vs)
   );

   // Sampled link clock: any toggle seen at the mclk sampler shows as activity
   sai_act_det #(.TMO(ACT_TMO_CYC)) u_det_dclk (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(link_clk_i),
      .active_o(det.dclk)
   );

   // ************************************************************
   // Source selection
   // ************************************************************
   always_comb
   begin
      analog_det = det.hs | det.green_embedded_sync | det.vs;
      any_det = analog_det | det.dclk;
      next_seek = 1'b0;
      next_sel_if = selected_interface_o;
      if (src_ovr[sai_pkg::OV_IF])
      begin
         next_sel_if = src_ovr[sai_pkg::OV_IF_PREF];
      end
      else if (analog_det && det.dclk)
      begin
         next_sel_if = src_ovr[sai_pkg::OV_IF_PREF];
      end
      else if (analog_det)
      begin
         next_sel_if = 1'b0;
      end
      else if (det.dclk)
      begin
         next_sel_if = 1'b1;
      end
      else
      begin
         next_seek = 1'b1;
      end
      if (src_ovr[sai_pkg::OV_HS] || (det.hs == det.green_embedded_sync))
         next_sel_hs = src_ovr[sai_pkg::OV_HS_PREF];
      else
         next_sel_hs = det.green_embedded_sync;
      if (src_ovr[sai_pkg::OV_VS])
         next_sel_vs = src_ovr[sai_pkg::OV_VS_PREF];
      else
         next_sel_vs = det.vs;
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         selected_interface_o <= 1'b0;
         selected_hsync_source_o <= 1'b0;
         selected_vsync_source_o <= 1'b0;
         seek_mode_o <= 1'b0;
         sync_detect_o <= 1'b0;
         out_oe_n_o <= 1'b0;
      end
      else
      begin
         selected_interface_o <= next_sel_if;
         selected_hsync_source_o <= next_sel_hs;
         selected_vsync_source_o <= next_sel_vs;
         seek_mode_o <= next_seek;
         sync_detect_o <= any_det ^ out_mode[sai_pkg::OM_DET_POL];
         out_oe_n_o <= out_mode[sai_pkg::OM_TRISTATE];
      end
   end

   // ************************************************************
   // AHB-Lite slave
   // ************************************************************
   always_comb
   begin
      addr_ok = (haddr_i[31:10] == '0) && (haddr_i[1:0] == 2'h0);
      ap_valid = hsel_i && hready_i && htrans_i[1];
      ap_idx = haddr_i[9:2];
      next_wr_pend = ap_valid && hwrite_i && addr_ok;
      next_wr_idx = ap_idx;
      irq_clr = 8'h00;
      next_out_mode = out_mode;
      next_src_ovr = src_ovr;
      next_irq_mask = irq_mask;
      if (wr_pend)
      begin
         unique case (wr_idx)
            sai_pkg::IDX_OUT_MODE:
               next_out_mode = hwdata_i[7:0] & sai_pkg::OUT_MODE_BITS;
            sai_pkg::IDX_SRC_OVR:
               next_src_ovr = hwdata_i[7:0] & sai_pkg::SRC_OVR_BITS;
            sai_pkg::IDX_IRQ_ST:
               irq_clr = hwdata_i[7:0] & sai_pkg::IRQ_BITS;
            sai_pkg::IDX_IRQ_MASK:
               next_irq_mask = hwdata_i[7:0] & sai_pkg::IRQ_BITS;
            default:
            begin
               // Detect status and unmapped words ignore writes
               next_out_mode = out_mode;
            end
         endcase
      end
   end

   // ************************************************************
   // Events and interrupt
   // ************************************************************
   always_comb
   begin
      irq_set = 8'h00;
      irq_set[sai_pkg::ST_HS] = det.hs ^ det_q.hs;
      irq_set[sai_pkg::ST_SOG] = det.green_embedded_sync ^ det_q.green_embedded_sync;
      irq_set[sai_pkg::ST_VS] = det.vs ^ det_q.vs;
      irq_set[sai_pkg::ST_DCLK] = det.dclk ^ det_q.dclk;
      irq_set[sai_pkg::ST_SEL_IF] = next_sel_if ^ selected_interface_o;
      // Set wins over a clear in the same cycle
      next_irq_st = (irq_st & ~irq_clr) | irq_set;
   end

   // ************************************************************
   // Read data, taken in the address phase
   // ************************************************************
   always_comb
   begin
      rd_val = 8'h00;
      unique case (ap_idx)
         sai_pkg::IDX_OUT_MODE:
            rd_val = next_out_mode;
         sai_pkg::IDX_DET_STAT:
         begin
            rd_val[sai_pkg::ST_HS] = det.hs;
            rd_val[sai_pkg::ST_SOG] = det.green_embedded_sync;
            rd_val[sai_pkg::ST_VS] = det.vs;
            rd_val[sai_pkg::ST_DCLK] = det.dclk;
            rd_val[sai_pkg::ST_SEL_IF] = selected_interface_o;
            rd_val[sai_pkg::ST_SEL_HS] = selected_hsync_source_o;
            rd_val[sai_pkg::ST_SEL_VS] = selected_vsync_source_o;
         end
         sai_pkg::IDX_SRC_OVR:
            rd_val = next_src_ovr;
         sai_pkg::IDX_IRQ_ST:
            rd_val = next_irq_st;
         sai_pkg::IDX_IRQ_MASK:
            rd_val = next_irq_mask;
         default:
            rd_val = 8'h00;
      endcase
      next_rdata = hrdata_o;
      if (ap_valid && !hwrite_i)
      begin
         next_rdata = addr_ok ? {24'h000000, rd_val} : 32'h00000000;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         out_mode <= sai_pkg::OUT_MODE_RST;
         src_ovr <= sai_pkg::SRC_OVR_RST;
         irq_mask <= sai_pkg::IRQ_MASK_RST;
         irq_st <= 8'h00;
         det_q <= '0;
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
         hrdata_o <= 32'h00000000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         out_mode <= next_out_mode;
         src_ovr <= next_src_ovr;
         irq_mask <= next_irq_mask;
         irq_st <= next_irq_st;
         det_q <= det;
         wr_pend <= next_wr_pend;
         wr_idx <= next_wr_idx;
         hrdata_o <= next_rdata;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         irq_o <= |(next_irq_st & next_irq_mask);
      end
   end

endmodule : sai_ctrl

// [tb/sai_ctrl_monitor.sv]
// Port checker of the sync activity and selection block
`timescale 1ns/1ps
// ****
// Checker
// ****
module sai_ctrl_monitor #(
   parameter logic [sai_pkg::TMO_W-1:0] ACT_TMO_CYC = sai_pkg::ACT_TMO_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   // Pins
   input wire logic hsync_i,
   input wire logic green_sync_i,
   input wire logic vsync_i,
   input wire logic link_clk_i,
   // Outputs
   input wire logic sync_detect_o,
   input wire logic out_oe_n_o,
   input wire logic selected_interface_o,
   input wire logic selected_hsync_source_o,
   input wire logic selected_vsync_source_o,
   input wire logic seek_mode_o
);
   localparam int TM = int'(ACT_TMO_CYC);
   logic [3:0] pv, p, k0, k1, kn;
   logic wv;
   logic rst_q;
   logic [31:0] wa;
   logic [7:0] om, ov, om_q, ov_q;
   int c[4];
   int e[4];
   assign pv = {hsync_i, green_sync_i, vsync_i, link_clk_i};
   // Pin surely idle, or surely active for a while
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         k0[i] = c[i] > TM + 12;
         k1[i] = c[i] <= TM - 8 && e[i] >= 8;
      end
   end
   assign kn = k0 | k1;
   // Pin age counters and register shadows
   always_ff @(posedge mclk_i)
   begin
      p <= pv;
      rst_q <= sys_rst_i;
      om_q <= om;
      ov_q <= ov;
      if (hready_i)
      begin
         wv <= hsel_i && htrans_i[1] && hwrite_i;
         wa <= haddr_i;
      end
      if (wv && hready_i && wa == 32'h00000040)
         om <= hwdata_i[7:0] & sai_pkg::OUT_MODE_BITS;
      if (wv && hready_i && wa == 32'h00000048)
         ov <= hwdata_i[7:0] & sai_pkg::SRC_OVR_BITS;
      for (int i = 0; i < 4; i++)
      begin
         c[i] <= sys_rst_i ? TM + 13 : pv[i] != p[i] ? 0 :
            c[i] > TM + 12 ? c[i] : c[i] + 1;
         e[i] <= (sys_rst_i || c[i] > TM + 12) ? 0 :
            e[i] > 14 ? 15 : e[i] + 1;
      end
      if (sys_rst_i)
      begin
         wv <= 1'b0;
         om <= 8'h00;
         ov <= 8'h00;
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   // Outputs still show reset values one edge after release
   default disable iff (sys_rst_i || rst_q);
   a_tri_follow: assert property (out_oe_n_o == om_q[3])
      else $error("output disable level wrong");
   a_pol_idle: assert property (&k0 |-> sync_detect_o == om_q[2])
      else $error("sync detect wrong while idle");
   a_pol_act: assert property (|k1 |-> sync_detect_o != om_q[2])
      else $error("sync detect wrong while active");
   a_if_ovr: assert property (ov_q[7] |->
      selected_interface_o == ov_q[6])
      else $error("forced interface wrong");
   a_if_auto: assert property (!ov_q[7] && &kn && |k1 |->
      selected_interface_o == (|k1[3:1] && k1[0] ? ov_q[6] : k1[0]))
      else $error("automatic interface wrong");
   a_seek_on: assert property (!ov_q[7] && &k0 |-> seek_mode_o)
      else $error("seek mode missing");
   a_seek_hold: assert property (seek_mode_o ##1 seek_mode_o |->
      $stable(selected_interface_o))
      else $error("interface moved while seeking");
   a_hs_sel: assert property (ov_q[5] || kn[3] && kn[2] |->
      selected_hsync_source_o == (ov_q[5] || k1[3] == k1[2] ?
      ov_q[4] : k1[2]))
      else $error("hsync source wrong");
   a_vs_sel: assert property (ov_q[3] || kn[1] |->
      selected_vsync_source_o == (ov_q[3] ? ov_q[2] : k1[1]))
      else $error("vsync source wrong");
   c_seek: cover property ($rose(seek_mode_o));
   c_both: cover property (|k1[3:1] && k1[0]);
   c_tri: cover property ($rose(out_oe_n_o));
endmodule : sai_ctrl_monitor

// [tb/sai_src_model.sv]
// Video source model driving the sync and link clock pins
`timescale 1ns/1ps
// ****
// Source
// ****
module sai_src_model (
   // Clock
   input wire logic mclk_i,
   // Pin enables
   input wire logic [3:0] en_i,
   // Pins
   output logic [3:0] pin_o
);
   int cnt[4];
   initial
   begin
      pin_o = 4'h0;
      cnt = '{0, 0, 0, 0};
   end
   // Each pin toggles at its own rate, held low when off
   always @(posedge mclk_i)
   begin
      for (int i = 0; i < 4; i++)
      begin
         cnt[i] <= cnt[i] >= 3 * i + 1 ? 0 : cnt[i] + 1;
         if (!en_i[i])
            pin_o[i] <= 1'b0;
         else if (cnt[i] == 0)
            pin_o[i] <= ~pin_o[i];
      end
   end
endmodule : sai_src_model

// [tb/sai_ctrl_tb_top.sv]
// Self-checking bench of the sync activity and selection block
`timescale 1ns/1ps
// ****
// Bench
// ****
module sai_ctrl_tb_top;
   localparam logic [sai_pkg::TMO_W-1:0] TMO = 20'h00040;
   localparam int TW = 100;
   localparam logic [31:0] A_OM = {22'h0, sai_pkg::IDX_OUT_MODE, 2'h0};
   localparam logic [31:0] A_ST = {22'h0, sai_pkg::IDX_DET_STAT, 2'h0};
   localparam logic [31:0] A_OV = {22'h0, sai_pkg::IDX_SRC_OVR, 2'h0};
   localparam logic [31:0] A_IS = {22'h0, sai_pkg::IDX_IRQ_ST, 2'h0};
   localparam logic [31:0] A_IM = {22'h0, sai_pkg::IDX_IRQ_MASK, 2'h0};
   logic mclk, rst, hsel, hwrite, hready, hresp, sdet, oe_n, sel_if;
   logic sel_hs, sel_vs, seek, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [3:0] en, pin;
   int bad_count = 0;
   int checks_done = 0;
   sai_ctrl #(.ACT_TMO_CYC(TMO)) dut_u (
      .mclk_i(mclk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .hsync_i(pin[3]),
      .green_sync_i(pin[2]), .vsync_i(pin[1]), .link_clk_i(pin[0]),
      .sync_detect_o(sdet), .out_oe_n_o(oe_n),
      .selected_interface_o(sel_if), .selected_hsync_source_o(sel_hs),
      .selected_vsync_source_o(sel_vs), .seek_mode_o(seek), .irq_o(irq));
   sai_src_model src_u (.mclk_i(mclk), .en_i(en), .pin_o(pin));
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [31:0] s,
      input logic [31:0] x);
      checks_done++;
      if (s !== x)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #10;
   endtask : step
   task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : xfer
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
      step(2);
   endtask : wr
   task automatic rd(input string n, input logic [31:0] a,
      input logic [31:0] x);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(n, r, x);
      chk("response", hresp, 1'b0);
   endtask : rd
   task automatic do_rst();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
   endtask : do_rst
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial
   begin
      #500000;
      bad_count++;
      $display("Watchdog expired");
      finish_test();
   end
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      en = 4'h0;
      do_rst();
      rd("mode", A_OM, 32'h00);
      rd("override", A_OV, 32'h00);
      rd("status", A_ST, 32'h00);
      rd("irq mask", A_IM, 32'h00);
      wr(32'h0000004C, 32'hFF);
      rd("unmapped", 32'h0000004C, 32'h00);
      chk("seek", seek, 1'b1);
      $display("Test reset done");
      wr(A_OM, 32'hFF);
      rd("mode", A_OM, 32'h0C);
      chk("oe_n", oe_n, 1'b1);
      chk("detect", sdet, 1'b1);
      wr(A_ST, 32'hFF);
      rd("status", A_ST, 32'h00);
      wr(A_OM, 32'h00);
      chk("oe_n", oe_n, 1'b0);
      $display("Test output mode done");
      en <= 4'h8;
      step(16);
      rd("status", A_ST, 32'h80);
      chk("detect", sdet, 1'b1);
      rd("irq status", A_IS, 32'h80);
      chk("irq", irq, 1'b0);
      wr(A_IM, 32'h80);
      chk("irq", irq, 1'b1);
      wr(A_IS, 32'h80);
      chk("irq", irq, 1'b0);
      $display("Test activity done");
      en <= 4'hC;
      step(16);
      rd("status", A_ST, 32'hC0);
      en <= 4'h4;
      step(TW);
      rd("status", A_ST, 32'h44);
      en <= 4'h7;
      step(16);
      rd("status", A_ST, 32'h76);
      wr(A_OV, 32'h40);
      rd("status", A_ST, 32'h7E);
      $display("Test selection done");
      wr(A_OV, 32'hAC);
      rd("override", A_OV, 32'hAC);
      rd("status", A_ST, 32'h72);
      wr(A_OV, 32'hFF);
      rd("override", A_OV, 32'hFC);
      rd("status", A_ST, 32'h7E);
      wr(A_OV, 32'h00);
      $display("Test override done");
      en <= 4'h1;
      step(TW);
      rd("status", A_ST, 32'h18);
      en <= 4'h0;
      step(TW);
      rd("status", A_ST, 32'h08);
      chk("seek", seek, 1'b1);
      rd("irq status", A_IS, 32'hF8);
      chk("irq", irq, 1'b1);
      $display("Test seek done");
      wr(A_OV, 32'hFC);
      do_rst();
      rd("override", A_OV, 32'h00);
      rd("status", A_ST, 32'h00);
      chk("irq", irq, 1'b0);
      $display("Test second reset done");
      finish_test();
   end
endmodule : sai_ctrl_tb_top

bind sai_ctrl sai_ctrl_monitor #(.ACT_TMO_CYC(ACT_TMO_CYC)) mon_u (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hsync_i(hsync_i),
   .green_sync_i(green_sync_i), .vsync_i(vsync_i),
   .link_clk_i(link_clk_i), .sync_detect_o(sync_detect_o),
   .out_oe_n_o(out_oe_n_o), .selected_interface_o(selected_interface_o),
   .selected_hsync_source_o(selected_hsync_source_o),
   .selected_vsync_source_o(selected_vsync_source_o),
   .seek_mode_o(seek_mode_o));
